// file: fcc_consts.svh
// Offsets, field positions, reset values and widths of the counter block.
// Assumes it is included by bare name after `default_nettype none.
`ifndef FCC_CONSTS_SVH
`define FCC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define FCC_OFF_CTRL 8'h00
`define FCC_OFF_CNT_LO 8'h04
`define FCC_OFF_CNT_HI 8'h08
`define FCC_OFF_TGT_LO 8'h0c
`define FCC_OFF_TGT_HI 8'h10
`define FCC_OFF_CMD 8'h14
`define FCC_OFF_STAGE 8'h18
`define FCC_OFF_FLAGS 8'h1c
`define FCC_OFF_INT_STAT 8'h20
`define FCC_OFF_INT_MASK 8'h24
`define FCC_OFF_RELAYS 8'h28

// ----------------------------------------------------------------------
// Control word bits
// ----------------------------------------------------------------------
`define FCC_CTL_W 4
`define FCC_CTL_SOFT_RST 0
`define FCC_CTL_CNT_DIS 1
`define FCC_CTL_HWR_DIS 2
`define FCC_CTL_CLEAR 3
`define FCC_CTL_RST 4'h0

// ----------------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------------
`define FCC_CMD_SEL_LSB 0
`define FCC_CMD_SEL_MSB 2
`define FCC_CMD_KIND_LSB 4
`define FCC_CMD_KIND_MSB 5

// ----------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------
`define FCC_INT_W 3
`define FCC_INT_MATCH 0
`define FCC_INT_REFUSED 1
`define FCC_INT_CLEARED 2

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define FCC_CNT_W 24
`define FCC_RELAY_N 8
`define FCC_CNT_RST 24'h000000
`define FCC_RELAY_RST 8'h00
`define FCC_WORD_ZERO 32'h0000_0000

`endif

// file: fcc_pkg.sv
// Types used by the counter compare block's command decode and bus slave.
// Assumes fcc_consts.svh is compiled alongside.
`default_nettype none

package fcc_pkg;
  // Command kinds carried in the command word
  typedef enum logic [1:0] {
    cmd_cmp_set,
    cmd_cmp_reset,
    cmd_pulse_pattern,
    cmd_cam_table
  } cmd_kind_t;

  // Bus slave data phase states
  typedef enum logic [0:0] {
    bus_idle,
    bus_rd_wait
  } bus_state_t;
endpackage

`default_nettype wire

// file: pin_sync_if.sv
// Carrier between the block core and its pin input filter.
// Assumes both ends share hclk.
`default_nettype none

interface pin_sync_if #(parameter int W = 3);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport core (output raw, input clean);
  modport filt (input raw, output clean);
endinterface

`default_nettype wire

// file: pin_sync.sv
// Three-stage pin filter: a change is taken once stages two and three agree.
// Assumes asynchronous pins and an active-low asynchronous reset.
`default_nettype none

module pin_sync #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Raw pins in, filtered levels out
  pin_sync_if.filt pins
);
  // ----------------------------------------------------------------------
  // Per-bit synchroniser
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < W; gi = gi + 1)
    begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      logic held;
      // Stage one feeds stage two only, to keep metastability contained
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          held <= 1'b0;
        end
        else
        begin
          s1 <= pins.raw[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3)
            held <= s3;
        end
      end
      assign pins.clean[gi] = held;
    end
  endgenerate
endmodule // pin_sync

`default_nettype wire

// file: fast_counter_compare_output.sv
// Fast pulse counter with compare output onto eight relays, AHB-Lite slave.
// Assumes a single-master AHB-Lite bus on hclk, async pins for counting.
// Behaviour
// - Control bit 3 set stops and clears all pending compare/pulse/cam work.
// - Control 1 zeroes the count; a later 0 lets counting go on.
// - Compare-set match switches the chosen relay on.
// - Each accepted compare command loads the target pair; a match clears it.
// - Active flag rises on a compare command, falls on the match.
// - Counter resets after a command leave the armed target alone.
// - While active, further compare, pulse and cam commands are refused.
// - Target is compared with the elapsed count register pair.
// - Control bit 0 set forces the count to zero and holds it.
// - Control bit 1 set ignores count inputs, count held.
// - Control bit 2 set ignores the hardware reset input.
`default_nettype none
`include "fcc_consts.svh"

module fast_counter_compare_output (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Counter pins
  input wire logic count_up_in,
  input wire logic count_down_in,
  input wire logic hardware_reset_input,
  // Relays and helper outputs
  output logic [`FCC_RELAY_N-1:0] output_relays_zero_to_seven,
  output logic compare_active_flag,
  output logic pulse_pattern_start,
  output logic cam_table_start,
  output logic clear_other_ops,
  output logic irq
);
  import fcc_pkg::*;

  // ----------------------------------------------------------------------
  // Pin filtering
  // ----------------------------------------------------------------------
  pin_sync_if #(.W(3)) pins ();
  assign pins.raw = {hardware_reset_input, count_down_in, count_up_in};

  pin_sync #(.W(3)) u_pin_sync (.hclk(hclk), .hresetn(hresetn), .pins(pins));

  logic up_d;
  logic down_d;
  wire up_f = pins.clean[0];
  wire down_f = pins.clean[1];
  wire hwr_f = pins.clean[2];

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [`FCC_CTL_W-1:0] counter_control_word;
  logic [`FCC_CNT_W-1:0] cnt;
  logic [`FCC_CNT_W-1:0] target;
  logic [`FCC_CNT_W-1:0] stage;
  logic [2:0] relay_sel;
  logic set_kind;
  logic [`FCC_INT_W-1:0] int_stat;
  logic [`FCC_INT_W-1:0] int_mask;
  bus_state_t bus_state;
  logic dp_valid;
  logic dp_write;
  logic [7:0] dp_addr;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire ap_take = hsel & htrans[1] & hready;
  wire ap_read = ap_take & ~hwrite;
  wire wr_en = dp_valid & dp_write;
  wire ctrl_wr = wr_en & (dp_addr == `FCC_OFF_CTRL);
  wire cmd_wr = wr_en & (dp_addr == `FCC_OFF_CMD);
  wire stage_wr = wr_en & (dp_addr == `FCC_OFF_STAGE);
  wire stat_wr = wr_en & (dp_addr == `FCC_OFF_INT_STAT);
  wire mask_wr = wr_en & (dp_addr == `FCC_OFF_INT_MASK);
  wire [7:0] rd_addr = {haddr[7:2], 2'b00};

  // ----------------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------------
  wire soft_rst = counter_control_word[`FCC_CTL_SOFT_RST];
  wire cnt_dis = counter_control_word[`FCC_CTL_CNT_DIS];
  wire hwr_dis = counter_control_word[`FCC_CTL_HWR_DIS];
  wire clr_ops = counter_control_word[`FCC_CTL_CLEAR];
  wire hwr_eff = hwr_f & ~hwr_dis;
  // Count step from filtered edges
  wire up_edge = up_f & ~up_d;
  wire down_edge = down_f & ~down_d;
  wire [`FCC_CNT_W-1:0] cnt_inc = cnt + `FCC_CNT_W'(1);
  wire [`FCC_CNT_W-1:0] cnt_dec = cnt - `FCC_CNT_W'(1);
  // zero wins over hold, hold over stepping
  wire [`FCC_CNT_W-1:0] next_cnt =
    (soft_rst | hwr_eff) ? `FCC_CNT_RST :
    cnt_dis ? cnt :
    (up_edge & ~down_edge) ? cnt_inc :
    (down_edge & ~up_edge) ? cnt_dec : cnt;

  // ----------------------------------------------------------------------
  // Compare and command decode
  // ----------------------------------------------------------------------
  // equality against the elapsed count every cycle
  wire match = compare_active_flag & ~clr_ops & (cnt == target);
  wire [1:0] kind_bits = hwdata[`FCC_CMD_KIND_MSB:`FCC_CMD_KIND_LSB];
  wire cmd_is_cmp = (kind_bits == cmd_cmp_set) |
                    (kind_bits == cmd_cmp_reset);
  // busy or clearing refuses every command
  wire cmd_ok = cmd_wr & ~compare_active_flag & ~clr_ops;
  wire cmd_refused = cmd_wr & ~cmd_ok;
  wire accept_cmp = cmd_ok & cmd_is_cmp;
  // Clearing only counts as an event when there was something to drop
  wire clear_evt = clr_ops & compare_active_flag;
  wire [`FCC_INT_W-1:0] int_events = {clear_evt, cmd_refused, match};

  // ----------------------------------------------------------------------
  // Read mux, registered into hrdata
  // ----------------------------------------------------------------------
  wire [31:0] cnt_lo = {16'h0000, cnt[15:0]};
  wire [31:0] cnt_hi = {16'h0000, {8{cnt[23]}}, cnt[23:16]};
  wire [31:0] tgt_lo = {16'h0000, target[15:0]};
  wire [31:0] tgt_hi = {16'h0000, {8{target[23]}}, target[23:16]};
  logic [31:0] rd_mux;
  // Unmapped addresses read as zero with an OKAY answer
  always_comb
  begin
    case (dp_addr)
      `FCC_OFF_CTRL: rd_mux = {28'h0000000, counter_control_word};
      `FCC_OFF_CNT_LO: rd_mux = cnt_lo;
      `FCC_OFF_CNT_HI: rd_mux = cnt_hi;
      `FCC_OFF_TGT_LO: rd_mux = tgt_lo;
      `FCC_OFF_TGT_HI: rd_mux = tgt_hi;
      `FCC_OFF_STAGE: rd_mux = {8'h00, stage};
      `FCC_OFF_FLAGS: rd_mux = {31'h00000000, compare_active_flag};
      `FCC_OFF_INT_STAT: rd_mux = {29'h00000000, int_stat};
      `FCC_OFF_INT_MASK: rd_mux = {29'h00000000, int_mask};
      `FCC_OFF_RELAYS: rd_mux = {24'h000000, output_relays_zero_to_seven};
      default: rd_mux = `FCC_WORD_ZERO;
    endcase
  end

  // ----------------------------------------------------------------------
  // Bus slave: writes zero-wait, reads one wait so data is current
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_state <= bus_idle;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= `FCC_WORD_ZERO;
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end
    else
    begin
      case (bus_state)
        bus_idle:
        begin
          dp_valid <= ap_take;
          dp_write <= hwrite;
          dp_addr <= rd_addr;
          if (ap_read)
          begin
            hreadyout <= 1'b0;
            bus_state <= bus_rd_wait;
          end
        end
        bus_rd_wait:
        begin
          // A write data phase ahead of us has already landed here
          dp_valid <= 1'b0;
          hrdata <= rd_mux;
          hreadyout <= 1'b1;
          bus_state <= bus_idle;
        end
        default: bus_state <= bus_idle;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Control word and counter
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      counter_control_word <= `FCC_CTL_RST;
      cnt <= `FCC_CNT_RST;
      up_d <= 1'b0;
      down_d <= 1'b0;
    end
    else
    begin
      // the stored word acts until rewritten
      if (ctrl_wr)
        counter_control_word <= hwdata[`FCC_CTL_W-1:0];
      cnt <= next_cnt;
      up_d <= up_f;
      down_d <= down_f;
    end
  end

  // ----------------------------------------------------------------------
  // Target, active flag and relays
  // ----------------------------------------------------------------------
  // Target only loads or clears here; counter resets never touch it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage <= `FCC_CNT_RST;
      target <= `FCC_CNT_RST;
      compare_active_flag <= 1'b0;
      relay_sel <= 3'h0;
      set_kind <= 1'b0;
      output_relays_zero_to_seven <= `FCC_RELAY_RST;
      pulse_pattern_start <= 1'b0;
      cam_table_start <= 1'b0;
      clear_other_ops <= 1'b0;
    end
    else
    begin
      // Upper bits beyond 24 are dropped; range is the caller's duty
      if (stage_wr)
        stage <= hwdata[`FCC_CNT_W-1:0];
      pulse_pattern_start <= cmd_ok & (kind_bits == cmd_pulse_pattern);
      cam_table_start <= cmd_ok & (kind_bits == cmd_cam_table);
      clear_other_ops <= clr_ops;
      if (clr_ops)
      begin
        compare_active_flag <= 1'b0;
        target <= `FCC_CNT_RST;
      end
      else if (accept_cmp)
      begin
        target <= stage;
        compare_active_flag <= 1'b1;
        relay_sel <= hwdata[`FCC_CMD_SEL_MSB:`FCC_CMD_SEL_LSB];
        set_kind <= (kind_bits == cmd_cmp_set);
      end
      else if (match)
      begin
        target <= `FCC_CNT_RST;
        compare_active_flag <= 1'b0;
        output_relays_zero_to_seven[relay_sel] <= set_kind;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts: sticky, write one to clear, set beats clear
  // ----------------------------------------------------------------------
  wire [`FCC_INT_W-1:0] w1c = stat_wr ? hwdata[`FCC_INT_W-1:0] :
                              `FCC_INT_W'(0);
  wire [`FCC_INT_W-1:0] next_int_stat = (int_stat & ~w1c) | int_events;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      int_stat <= `FCC_INT_W'(0);
      int_mask <= `FCC_INT_W'(0);
      irq <= 1'b0;
    end
    else
    begin
      int_stat <= next_int_stat;
      if (mask_wr)
        int_mask <= hwdata[`FCC_INT_W-1:0];
      irq <= |(next_int_stat & int_mask);
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb_assert @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_armed_set;
    match && set_kind;
  endsequence
  sequence s_armed_reset;
    match && !set_kind;
  endsequence

  property p_clear_stops;
    clr_ops |=> !compare_active_flag && target == `FCC_CNT_RST;
  endproperty
  a_clear_stops: assert property (p_clear_stops)
    else $error("clear bit did not drop the compare");
  property p_soft_zero;
    soft_rst |=> cnt == `FCC_CNT_RST;
  endproperty
  a_soft_zero: assert property (p_soft_zero)
    else $error("software reset did not zero the count");
  property p_hold;
    cnt_dis && !soft_rst && !hwr_eff |=> cnt == $past(cnt);
  endproperty
  a_hold: assert property (p_hold)
    else $error("count moved while disabled");
  property p_hwr;
    hwr_f && !hwr_dis |=> cnt == `FCC_CNT_RST;
  endproperty
  a_hwr: assert property (p_hwr)
    else $error("enabled hardware reset did not zero the count");
  property p_set_on;
    s_armed_set |=> output_relays_zero_to_seven[$past(relay_sel)];
  endproperty
  a_set_on: assert property (p_set_on)
    else $error("set match left relay off");
  property p_reset_off;
    s_armed_reset |=> !output_relays_zero_to_seven[$past(relay_sel)];
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("reset match left relay on");
  property p_load;
    accept_cmp |=> compare_active_flag && target == $past(stage);
  endproperty
  a_load: assert property (p_load)
    else $error("compare command did not load target");
  property p_match_drop;
    match |=> !compare_active_flag ##0 target == `FCC_CNT_RST;
  endproperty
  a_match_drop: assert property (p_match_drop)
    else $error("match did not clear flag and target");
  property p_keep_armed;
    compare_active_flag && !match && !clr_ops |=> compare_active_flag
      && $stable(target);
  endproperty
  a_keep_armed: assert property (p_keep_armed)
    else $error("armed target lost without a match");
  property p_refuse;
    cmd_wr && compare_active_flag |=> !pulse_pattern_start
      && !cam_table_start && int_stat[`FCC_INT_REFUSED];
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("command accepted while busy");
  property p_first_equal;
    compare_active_flag && !clr_ops && cnt == target |=> !compare_active_flag;
  endproperty
  a_first_equal: assert property (p_first_equal)
    else $error("equal count not acted on");
endmodule // fast_counter_compare_output

`default_nettype wire

// file: scan_master.sv
// Scan program model: AHB-Lite master plus the counter's field pins.
// Assumes one slave whose hreadyout comes back as hready.
`default_nettype none
`include "fcc_consts.svh"

module scan_master (
  // Clock and bus answer
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Bus request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // Field pins
  output logic count_up_in,
  output logic count_down_in,
  output logic hardware_reset_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] pins;

  // Pin 0 counts up, 1 counts down, 2 is the hardware reset
  assign count_up_in = pins[0];
  assign count_down_in = pins[1];
  assign hardware_reset_input = pins[2];

  // Idle bus at time zero
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    pins = 3'h0;
  end

  // Ready sampled at the rising edge; answer data taken at that same edge
  task automatic wait_ready(output logic [31:0] d);
    do
    begin
      @(posedge hclk);
    end
    while (hready !== 1'b1);
    d = hrdata;
  endtask

  task automatic addr_phase(input logic [7:0] a, input logic w);
    logic [31:0] dummy;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready(dummy);
    hsel <= 1'b0;
    htrans <= 2'h0;
  endtask

  // Released write data shows the inverse so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    addr_phase(a, 1'b1);
    hwdata <= d;
    wait_ready(dummy);
    hwdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr_phase(a, 1'b0);
    wait_ready(d);
  endtask

  // target kept to 24 signed bits
  task automatic stage(input logic [23:0] v);
    wr(`FCC_OFF_STAGE, {8'h00, v});
  endtask

  task automatic command(input logic [1:0] kind, input logic [2:0] rel);
    wr(`FCC_OFF_CMD, {26'h0000000, kind, 1'b0, rel});
  endtask

  // Pin held long enough to pass the three-stage filter
  task automatic pulse(input int pin, input int len);
    @(posedge hclk);
    pins[pin] <= 1'b1;
    repeat (len) @(posedge hclk);
    pins[pin] <= 1'b0;
    repeat (len) @(posedge hclk);
  endtask
endmodule // scan_master

`default_nettype wire

// file: tb_top.sv
// Self-checking bench of the counter compare block.
// Assumes the scan_master model and the design files are compiled first.
`default_nettype none
`include "fcc_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic cup, cdn, hwr, flag, pp, cam, clr, seen_pp, seen_cam;
  logic [7:0] relays;
  int mismatches, compares;

  fast_counter_compare_output u_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .count_up_in(cup),
    .count_down_in(cdn), .hardware_reset_input(hwr),
    .output_relays_zero_to_seven(relays), .compare_active_flag(flag),
    .pulse_pattern_start(pp), .cam_table_start(cam),
    .clear_other_ops(clr), .irq(irq));

  scan_master u_m (.hclk(hclk), .hready(hready), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .count_up_in(cup),
    .count_down_in(cdn), .hardware_reset_input(hwr));

  always #4 hclk = ~hclk;

  // Start pulses last one cycle, so they are latched here
  always @(posedge hclk)
  begin
    if (pp === 1'b1) seen_pp <= 1'b1;
    if (cam === 1'b1) seen_cam <= 1'b1;
  end

  // ------------------------------------------------------------------
  // Shared checks
  // ------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input string n);
    logic [31:0] d;
    u_m.rd(a, d);
    chk(n, e, d);
  endtask

  // Bounded wait for the armed compare to fire
  task automatic wait_match();
    int i;
    for (i = 0; i < 80 && flag !== 1'b0; i++) @(negedge hclk);
    chk("flag after match", 32'h0, {31'h0, flag});
  endtask

  task automatic end_of_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_values();
    logic [7:0] offs [9];
    offs = '{`FCC_OFF_CTRL, `FCC_OFF_CNT_LO, `FCC_OFF_CNT_HI,
      `FCC_OFF_TGT_LO, `FCC_OFF_FLAGS, `FCC_OFF_INT_STAT,
      `FCC_OFF_INT_MASK, `FCC_OFF_RELAYS, 8'h40};
    foreach (offs[i]) rchk(offs[i], 32'h0, "reset value");
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic t_compare_set();
    u_m.wr(`FCC_OFF_INT_MASK, 32'h1);
    u_m.stage(24'h000003);
    u_m.command(2'h0, 3'h5);
    rchk(`FCC_OFF_FLAGS, 32'h1, "flag armed");
    rchk(`FCC_OFF_TGT_LO, 32'h3, "target stored");
    repeat (3) u_m.pulse(0, 6);
    wait_match();
    rchk(`FCC_OFF_RELAYS, 32'h20, "relay on");
    chk("relay pin on", 32'h20, {24'h0, relays});
    rchk(`FCC_OFF_CNT_LO, 32'h3, "count at match");
    rchk(`FCC_OFF_TGT_LO, 32'h0, "target cleared");
    chk("irq raised", 32'h1, {31'h0, irq});
    u_m.wr(`FCC_OFF_INT_STAT, 32'h1);
    repeat (2) @(negedge hclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask

  task automatic t_compare_reset();
    u_m.stage(24'hfffffe);
    u_m.command(2'h1, 3'h5);
    rchk(`FCC_OFF_TGT_HI, 32'hffff, "target sign");
    u_m.command(2'h0, 3'h2);
    rchk(`FCC_OFF_INT_STAT, 32'h2, "refused status");
    chk("irq masked", 32'h0, {31'h0, irq});
    u_m.wr(`FCC_OFF_CTRL, 32'h1);
    u_m.pulse(0, 6);
    rchk(`FCC_OFF_CNT_LO, 32'h0, "soft reset");
    u_m.wr(`FCC_OFF_CTRL, 32'h0);
    rchk(`FCC_OFF_FLAGS, 32'h1, "armed after reset");
    rchk(`FCC_OFF_TGT_LO, 32'hfffe, "target kept");
    repeat (2) u_m.pulse(1, 6);
    wait_match();
    rchk(`FCC_OFF_RELAYS, 32'h0, "relay off");
    chk("relay pin off", 32'h0, {24'h0, relays});
  endtask

  task automatic t_hold_modes();
    u_m.wr(`FCC_OFF_CTRL, 32'h2);
    u_m.pulse(0, 6);
    rchk(`FCC_OFF_CNT_LO, 32'hfffe, "count held");
    u_m.wr(`FCC_OFF_CTRL, 32'h4);
    u_m.pulse(2, 6);
    rchk(`FCC_OFF_CNT_HI, 32'hffff, "hw reset off");
    u_m.wr(`FCC_OFF_CTRL, 32'h0);
    u_m.pulse(2, 6);
    rchk(`FCC_OFF_CNT_LO, 32'h0, "hw reset on");
  endtask

  task automatic t_clear_ops();
    u_m.wr(`FCC_OFF_INT_STAT, 32'h7);
    u_m.stage(24'h000064);
    u_m.command(2'h0, 3'h1);
    u_m.wr(`FCC_OFF_CTRL, 32'h8);
    repeat (2) @(negedge hclk);
    chk("clear out", 32'h1, {31'h0, clr});
    rchk(`FCC_OFF_FLAGS, 32'h0, "cleared flag");
    u_m.command(2'h2, 3'h0);
    rchk(`FCC_OFF_INT_STAT, 32'h6, "clear status");
    chk("pulse held off", 32'h0, {31'h0, seen_pp});
    u_m.wr(`FCC_OFF_CTRL, 32'h0);
    u_m.command(2'h2, 3'h0);
    u_m.command(2'h3, 3'h0);
    // Start pulse launched at the last edge is latched one edge later
    repeat (2) @(negedge hclk);
    chk("pulse start", 32'h1, {31'h0, seen_pp});
    chk("cam start", 32'h1, {31'h0, seen_cam});
    u_m.wr(`FCC_OFF_RELAYS, 32'hff);
    rchk(`FCC_OFF_RELAYS, 32'h0, "relays read only");
  endtask

  // Main sequence
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    seen_pp = 1'b0;
    seen_cam = 1'b0;
    mismatches = 0;
    compares = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_values();
    t_compare_set();
    t_compare_reset();
    t_hold_modes();
    t_clear_ops();
    end_of_test();
  end

  // Watchdog: whole run needs well under 5000 cycles
  initial
  begin
    #100000;
    mismatches++;
    end_of_test();
  end
endmodule // tb_top

`default_nettype wire
